// *** edge_detect.sv ***
// rising and falling edge pulses of one filtered level
`timescale 1ns/1ps
module edge_detect (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);

  logic prev_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_q;
  assign fall_o = ~level_i & prev_q;

endmodule : edge_detect

// *** input_filter.sv ***
// synchroniser and stable-level filter for one command input
`timescale 1ns/1ps
module input_filter #(
  parameter int CYC   = 2,
  parameter int CNT_W = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic in_i,
  output logic      level_o
);

  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(CYC - 1);
  localparam logic [CNT_W-1:0] ONE   = CNT_W'(1);

  logic             meta_q;
  logic             sync_q;
  logic             level_q;
  logic [CNT_W-1:0] cnt_q;
  wire              differs = sync_q != level_q;
  wire              settled = cnt_q == LIMIT;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= in_i;
      sync_q <= meta_q;
    end
  end

  // new level only after it stood unchanged for CYC cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_q <= 1'b0;
      cnt_q   <= '0;
    end else if (!differs) begin
      cnt_q <= '0;
    end else if (settled) begin
      level_q <= sync_q;
      cnt_q   <= '0;
    end else begin
      cnt_q <= cnt_q + ONE;
    end
  end

  assign level_o = level_q;

  stable_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(level_q) |-> $past(cnt_q) == LIMIT)
    else $error("filtered level changed before settle time");

endmodule : input_filter

// *** remote_command_input_gate.sv ***
// remote command input gate: filters, acceptance checks, action pulses
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module remote_command_input_gate
  import remote_gate_pkg::*;
#(
  parameter int FILTER_CYCLES_P = FILTER_CYCLES
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [DATA_W-1:0] WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [DATA_W-1:0] RDATA_O,
  input  wire logic [GIN_W-1:0]  GENERAL_IN_I,
  input  wire logic              MOTOR_ENERGIZE_REQUEST_I,
  input  wire logic              MOTOR_DEENERGIZE_REQUEST_I,
  input  wire logic              PARK_REQUEST_I,
  input  wire logic              FORCED_REDUCED_POWER_INPUT_I,
  input  wire logic              STARTUP_DONE_I,
  input  wire logic              TASK_ACTIVE_I,
  input  wire logic              TASK_PAUSED_I,
  input  wire logic              ERROR_EVENT_I,
  input  wire logic              EMERGENCY_HALT_EVENT_I,
  input  wire logic              GUARD_OPEN_I,
  input  wire logic              CRITICAL_ERROR_I,
  input  wire logic              WARNING_I,
  input  wire logic              MOTORS_ENERGIZED_I,
  input  wire logic              REMOTE_MODE_I,
  output logic      [GOUT_W-1:0] GENERAL_OUT_O,
  output logic                   REMOTE_ACCEPTANCE_STATUS_O,
  output logic                   MOTORS_ENERGIZED_STATUS_O,
  output logic      [FN_W-1:0]   MAIN_FUNCTION_O,
  output logic                   RUN_LAUNCH_O,
  output logic                   HALT_ALL_O,
  output logic                   HOLD_TASKS_O,
  output logic                   RESUME_TASKS_O,
  output logic                   FAULT_CLEAR_O,
  output logic                   GENERAL_OUT_CLEAR_O,
  output logic                   PARAM_INIT_O,
  output logic                   MOTOR_ON_O,
  output logic                   MOTOR_OFF_O,
  output logic                   PARK_MOVE_O,
  output logic                   LOW_POWER_O
);

  // raw level vector in filter order
  logic [NUM_LV-1:0]  raw_w;
  logic [NUM_LV-1:0]  lv;
  logic [NUM_CMD-1:0] cmd_lv;
  logic [NUM_CMD-1:0] rise;
  logic [NUM_CMD-1:0] fall;
  logic [NUM_CMD-1:0] acc;
  logic [NUM_CMD-1:0] take;

  // status flops
  logic              ready_q;
  logic              running_q;
  logic              paused_q;
  logic              error_q;
  logic              estop_q;
  logic              guard_q;
  logic              crit_q;
  logic              warn_q;
  logic              motors_q;
  logic              remote_q;
  logic [DATA_W-1:0] ctrl_q;

  // action flops
  logic               run_q;
  logic               halt_q;
  logic               hold_q;
  logic               resume_q;
  logic               fclr_q;
  logic               gclr_q;
  logic               pinit_q;
  logic               mon_q;
  logic               moff_q;
  logic               park_q;
  logic               lowpwr_q;
  logic [FN_W-1:0]    fn_q;
  logic [NUM_CMD-1:0] last_q;
  logic [DATA_W-1:0]  rdata_q;

  // default mapping of general inputs plus the extra inputs
  assign raw_w = {FORCED_REDUCED_POWER_INPUT_I, PARK_REQUEST_I,
                  MOTOR_DEENERGIZE_REQUEST_I, MOTOR_ENERGIZE_REQUEST_I,
                  GENERAL_IN_I};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LV; gi++) begin : g_filt
      input_filter #(
        .CYC   (FILTER_CYCLES_P),
        .CNT_W (FILTER_CNT_W)
      ) u_filt (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .in_i    (raw_w[gi]),
        .level_o (lv[gi])
      );
    end
  endgenerate

  // command levels; select bits take no slot
  assign cmd_lv[CMD_RUN]    = lv[GIN_RUN];
  assign cmd_lv[CMD_HALT]   = lv[GIN_HALT];
  assign cmd_lv[CMD_HOLD]   = lv[GIN_HOLD];
  assign cmd_lv[CMD_RESUME] = lv[GIN_RESUME];
  assign cmd_lv[CMD_FCLR]   = lv[GIN_FCLR];
  assign cmd_lv[CMD_MON]    = lv[LV_MON];
  assign cmd_lv[CMD_MOFF]   = lv[LV_MOFF];
  assign cmd_lv[CMD_PARK]   = lv[LV_PARK];
  assign cmd_lv[CMD_LOWPWR] = lv[LV_LOWPWR];

  generate
    for (gi = 0; gi < NUM_CMD; gi++) begin : g_edge
      edge_detect u_edge (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .level_i (cmd_lv[gi]),
        .rise_o  (rise[gi]),
        .fall_o  (fall[gi])
      );
    end
  endgenerate

  // acceptance conditions
  wire hold_in   = lv[GIN_HOLD];
  wire halt_in   = lv[GIN_HALT];
  wire base_ok   = remote_q & ~error_q;
  wire no_fault  = ~estop_q & ~guard_q;
  wire not_held  = ~hold_in & ~halt_in;
  wire [FN_W-1:0] sel_w = {lv[GIN_SEL_W4], lv[GIN_SEL_W2], lv[GIN_SEL_W1]};

  assign acc[CMD_RUN]    = base_ok & ready_q & no_fault & not_held;
  assign acc[CMD_HALT]   = base_ok;
  assign acc[CMD_HOLD]   = base_ok & running_q;
  assign acc[CMD_RESUME] = base_ok & paused_q & not_held;
  assign acc[CMD_FCLR]   = remote_q & ready_q;
  assign acc[CMD_MON]    = base_ok & ready_q & no_fault & ~lv[LV_MOFF];
  assign acc[CMD_MOFF]   = base_ok & ready_q;
  assign acc[CMD_PARK]   = base_ok & ready_q & no_fault & motors_q & not_held;
  assign acc[CMD_LOWPWR] = 1'b1;

  // two or more command edges other than low power at once raise an error and fire nothing but a low power edge
  localparam logic [NUM_CMD-1:0] PWR_MASK = NUM_CMD'(1) << CMD_LOWPWR;
  localparam logic [NUM_CMD-1:0] ONE_CMD  = NUM_CMD'(1);
  wire [NUM_CMD-1:0] rise_cmd = rise & ~PWR_MASK;
  wire               multi    = |(rise_cmd & (rise_cmd - ONE_CMD));
  wire [NUM_CMD-1:0] pass_w   = multi ? PWR_MASK : {NUM_CMD{1'b1}};

  // one shot per edge; a refused edge is simply lost
  assign take = rise & acc & pass_w;

  wire err_set  = ERROR_EVENT_I | multi;
  wire err_d    = err_set | (error_q & ~take[CMD_FCLR]);
  wire estop_d  = EMERGENCY_HALT_EVENT_I | (estop_q & ~take[CMD_FCLR]);
  wire ready_d  = STARTUP_DONE_I & ~TASK_ACTIVE_I;
  wire remote_d = ctrl_q[CTRL_REMOTE_SEL] & REMOTE_MODE_I;
  wire halt_d   = take[CMD_HALT] | take[CMD_LOWPWR] | fall[CMD_LOWPWR];

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ready_q   <= 1'b0;
      running_q <= 1'b0;
      paused_q  <= 1'b0;
      guard_q   <= 1'b0;
      crit_q    <= 1'b0;
      warn_q    <= 1'b0;
      motors_q  <= 1'b0;
      remote_q  <= 1'b0;
    end else begin
      ready_q   <= ready_d;
      running_q <= TASK_ACTIVE_I & ~TASK_PAUSED_I;
      paused_q  <= TASK_PAUSED_I;
      guard_q   <= GUARD_OPEN_I;
      crit_q    <= CRITICAL_ERROR_I;
      warn_q    <= WARNING_I;
      motors_q  <= MOTORS_ENERGIZED_I;
      remote_q  <= remote_d;
    end
  end

  // sticky fault states, set wins over clear
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      error_q <= 1'b0;
      estop_q <= 1'b0;
    end else begin
      error_q <= err_d;
      estop_q <= estop_d;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      run_q    <= 1'b0;
      halt_q   <= 1'b0;
      hold_q   <= 1'b0;
      resume_q <= 1'b0;
      fclr_q   <= 1'b0;
      gclr_q   <= 1'b0;
      pinit_q  <= 1'b0;
      mon_q    <= 1'b0;
      moff_q   <= 1'b0;
      park_q   <= 1'b0;
      lowpwr_q <= 1'b0;
    end else begin
      run_q    <= take[CMD_RUN];
      halt_q   <= halt_d;
      hold_q   <= take[CMD_HOLD];
      resume_q <= take[CMD_RESUME];
      fclr_q   <= take[CMD_FCLR];
      gclr_q   <= take[CMD_FCLR];
      pinit_q  <= take[CMD_FCLR] | take[CMD_MON];
      mon_q    <= take[CMD_MON];
      moff_q   <= take[CMD_MOFF];
      park_q   <= take[CMD_PARK];
      lowpwr_q <= lv[LV_LOWPWR];
    end
  end

  // current or last main function, last accepted command
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fn_q   <= '0;
      last_q <= '0;
    end else begin
      if (take[CMD_RUN]) begin
        fn_q <= sel_w;
      end
      if (|take) begin
        last_q <= take;
      end
    end
  end

  // register port
  wire wr_ctrl = WR_I && (ADDR_I == REG_CTRL);
  wire [GOUT_W-1:0] gout_w;
  wire [DATA_W-1:0] status_w;
  wire [DATA_W-1:0] last_w;
  wire [DATA_W-1:0] rd_mux;

  assign gout_w[GOUT_READY]   = ready_q;
  assign gout_w[GOUT_RUNNING] = running_q;
  assign gout_w[GOUT_PAUSED]  = paused_q;
  assign gout_w[GOUT_ERROR]   = error_q;
  assign gout_w[GOUT_EHALT]   = estop_q;
  assign gout_w[GOUT_GUARD]   = guard_q;
  assign gout_w[GOUT_CRIT]    = crit_q;
  assign gout_w[GOUT_WARN]    = warn_q;

  assign status_w = (DATA_W'(gout_w) << STAT_GOUT_LSB)
                  | (DATA_W'(remote_q) << STAT_REMOTE)
                  | (DATA_W'(motors_q) << STAT_MOTORS)
                  | (DATA_W'(lowpwr_q) << STAT_LOWPWR);
  assign last_w   = (DATA_W'(last_q) << LAST_CMD_LSB) | (DATA_W'(fn_q) << LAST_FN_LSB);
  assign rd_mux   = (ADDR_I == REG_CTRL)   ? ctrl_q   :
                    (ADDR_I == REG_STATUS) ? status_w :
                    (ADDR_I == REG_LAST)   ? last_w   : '0;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_q  <= CTRL_RESET;
      rdata_q <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= WDATA_I & (DATA_W'(1) << CTRL_REMOTE_SEL);
      end
      rdata_q <= RD_I ? rd_mux : '0;
    end
  end

  assign RDATA_O                    = rdata_q;
  assign GENERAL_OUT_O              = gout_w;
  assign REMOTE_ACCEPTANCE_STATUS_O = remote_q;
  assign MOTORS_ENERGIZED_STATUS_O  = motors_q;
  assign MAIN_FUNCTION_O            = fn_q;
  assign RUN_LAUNCH_O               = run_q;
  assign HALT_ALL_O                 = halt_q;
  assign HOLD_TASKS_O               = hold_q;
  assign RESUME_TASKS_O             = resume_q;
  assign FAULT_CLEAR_O              = fclr_q;
  assign GENERAL_OUT_CLEAR_O        = gclr_q;
  assign PARAM_INIT_O               = pinit_q;
  assign MOTOR_ON_O                 = mon_q;
  assign MOTOR_OFF_O                = moff_q;
  assign PARK_MOVE_O                = park_q;
  assign LOW_POWER_O                = lowpwr_q;

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  wire any_cmd_q = run_q | hold_q | resume_q | mon_q | moff_q | park_q;

  run_accept_a: assert property (
    run_q |-> $past(ready_q && !error_q && !estop_q && !guard_q && !hold_in && !halt_in))
    else $error("run launched without its conditions");
  remote_gate_a: assert property (
    (any_cmd_q || fclr_q) |-> $past(remote_q))
    else $error("command fired without remote acceptance");
  error_block_a: assert property (
    any_cmd_q |-> !$past(error_q))
    else $error("command fired while error pending");
  hold_running_a: assert property (
    hold_q |-> $past(running_q))
    else $error("hold fired while not running");
  resume_cond_a: assert property (
    resume_q |-> $past(paused_q && !hold_in && !halt_in))
    else $error("resume fired without its conditions");
  motor_on_a: assert property (
    mon_q |-> $past(ready_q && !estop_q && !guard_q && !lv[LV_MOFF]) && pinit_q)
    else $error("motor on fired without its conditions");
  park_cond_a: assert property (
    park_q |-> $past(ready_q && motors_q && !estop_q && !guard_q && !error_q))
    else $error("park fired without its conditions");
  power_level_a: assert property (
    $rose(lv[LV_LOWPWR]) |=> lowpwr_q && halt_q)
    else $error("forced low power not taken");
  power_fall_a: assert property (
    $fell(lv[LV_LOWPWR]) |=> halt_q ##1 !lowpwr_q)
    else $error("no halt on forced low power release");
  single_shot_a: assert property (
    run_q |=> !run_q [*2])
    else $error("run pulse repeated");
  fault_clear_a: assert property (
    fclr_q && !$past(ERROR_EVENT_I) && !$past(EMERGENCY_HALT_EVENT_I)
    |-> !error_q && !estop_q && gclr_q)
    else $error("fault clear did not clear error");
  ready_track_a: assert property (
    $past(RST_N_I) |-> ready_q == $past(STARTUP_DONE_I && !TASK_ACTIVE_I))
    else $error("ready does not follow startup and tasks");
  remote_stat_a: assert property (
    $past(RST_N_I) |-> remote_q == $past(ctrl_q[CTRL_REMOTE_SEL] && REMOTE_MODE_I))
    else $error("remote acceptance output wrong");

  run_seen_c:    cover property (run_q ##[1:50] hold_q);
  refused_c:     cover property (rise[CMD_RUN] && !acc[CMD_RUN]);
  overlap_c:     cover property (multi ##1 error_q);
  power_cycle_c: cover property ($rose(lowpwr_q) ##[1:100] $fell(lowpwr_q));

endmodule : remote_command_input_gate

// *** remote_gate_pkg.sv ***
// constants shared by the remote command input gate
package remote_gate_pkg;

  // clock and input filter timing
  localparam int CLK_HZ         = 20_000_000;
  localparam int HZ_PER_MHZ     = 1_000_000;
  localparam int FILTER_TIME_US = 1000;
  localparam int FILTER_CYCLES  = FILTER_TIME_US * (CLK_HZ / HZ_PER_MHZ);
  localparam int FILTER_CNT_W   = 16;

  // positions on the general input port
  localparam int GIN_RUN     = 0;
  localparam int GIN_SEL_W1  = 1;
  localparam int GIN_SEL_W2  = 2;
  localparam int GIN_SEL_W4  = 3;
  localparam int GIN_HALT    = 4;
  localparam int GIN_HOLD    = 5;
  localparam int GIN_RESUME  = 6;
  localparam int GIN_FCLR    = 7;
  localparam int GIN_W       = 8;

  // positions on the general output port
  localparam int GOUT_READY   = 0;
  localparam int GOUT_RUNNING = 1;
  localparam int GOUT_PAUSED  = 2;
  localparam int GOUT_ERROR   = 3;
  localparam int GOUT_EHALT   = 4;
  localparam int GOUT_GUARD   = 5;
  localparam int GOUT_CRIT    = 6;
  localparam int GOUT_WARN    = 7;
  localparam int GOUT_W       = 8;

  // filtered level vector: general inputs first, then the extra inputs
  localparam int LV_MON    = 8;
  localparam int LV_MOFF   = 9;
  localparam int LV_PARK   = 10;
  localparam int LV_LOWPWR = 11;
  localparam int NUM_LV    = 12;

  // command slots
  localparam int CMD_RUN    = 0;
  localparam int CMD_HALT   = 1;
  localparam int CMD_HOLD   = 2;
  localparam int CMD_RESUME = 3;
  localparam int CMD_FCLR   = 4;
  localparam int CMD_MON    = 5;
  localparam int CMD_MOFF   = 6;
  localparam int CMD_PARK   = 7;
  localparam int CMD_LOWPWR = 8;
  localparam int NUM_CMD    = 9;
  localparam int FN_W       = 3;

  // register port
  localparam int                ADDR_W     = 4;
  localparam int                DATA_W     = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_LAST   = 4'h8;
  localparam int                CTRL_REMOTE_SEL = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET      = 32'h0000_0000;
  localparam int                STAT_GOUT_LSB   = 0;
  localparam int                STAT_REMOTE     = 8;
  localparam int                STAT_MOTORS     = 9;
  localparam int                STAT_LOWPWR     = 10;
  localparam int                LAST_CMD_LSB    = 0;
  localparam int                LAST_FN_LSB     = 16;

endpackage : remote_gate_pkg

// *** remote_panel_model.sv ***
// remote panel model: drives one command line at a time
`timescale 1ns/1ps
module remote_panel_model #(
  parameter int HOLD_CYC = 12
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       go_i,
  input  wire logic [3:0] cmd_i,
  input  wire logic [2:0] sel_i,
  output logic      [7:0] gin_o,
  output logic            mon_o,
  output logic            moff_o,
  output logic            park_o,
  output logic            lowpwr_o,
  output logic            busy_o
);
  logic [8:0] line_q;
  int         cnt_q;

  assign gin_o    = {line_q[4:1], sel_i, line_q[0]};
  assign mon_o    = line_q[5];
  assign moff_o   = line_q[6];
  assign park_o   = line_q[7];
  assign lowpwr_o = line_q[8];
  assign busy_o   = cnt_q != 0;

  // one line held, then a quiet gap as long before the next
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_q <= 9'h000;
      cnt_q  <= 0;
    end else if (go_i && cnt_q == 0) begin
      line_q <= 9'h001 << cmd_i;
      cnt_q  <= 2 * HOLD_CYC;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == HOLD_CYC) begin
        line_q <= 9'h000;
      end
    end
  end
endmodule : remote_panel_model

// *** tb.sv ***
// testbench for the remote command input gate
`timescale 1ns/1ps
module tb;
  import remote_gate_pkg::*;
  localparam int FILT = 4;
  typedef struct packed {
    logic [5:0]  ctx;
    logic [3:0]  cmd;
    logic [10:0] exp;
  } row_t;
  logic              clk, rst_n, wr, rd, go, err_ev, estop, crit, warn;
  logic              mon, moff, park, lowpwr, busy, remote, motors, lp_o;
  logic              run_p, halt_p, hold_p, res_p, fclr_p, goclr_p, pinit_p;
  logic              mon_p, moff_p, park_p;
  logic [5:0]        ctx;
  logic [3:0]        cmd;
  logic [2:0]        sel;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [GIN_W-1:0]  gin;
  logic [GOUT_W-1:0] gout;
  logic [FN_W-1:0]   fn;
  logic [10:0]       pulses, seen;
  int                n_errors, samples_checked, n_halt;
  row_t              rows [17];

  // ctx: mode, startup, task, paused, guard, motors
  remote_command_input_gate #(.FILTER_CYCLES_P(FILT)) remote_command_input_gate_i (
    .CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .GENERAL_IN_I(gin), .MOTOR_ENERGIZE_REQUEST_I(mon),
    .MOTOR_DEENERGIZE_REQUEST_I(moff), .PARK_REQUEST_I(park),
    .FORCED_REDUCED_POWER_INPUT_I(lowpwr), .STARTUP_DONE_I(ctx[4]),
    .TASK_ACTIVE_I(ctx[3]), .TASK_PAUSED_I(ctx[2]), .ERROR_EVENT_I(err_ev),
    .EMERGENCY_HALT_EVENT_I(estop), .GUARD_OPEN_I(ctx[1]), .CRITICAL_ERROR_I(crit),
    .WARNING_I(warn), .MOTORS_ENERGIZED_I(ctx[0]), .REMOTE_MODE_I(ctx[5]),
    .GENERAL_OUT_O(gout), .REMOTE_ACCEPTANCE_STATUS_O(remote),
    .MOTORS_ENERGIZED_STATUS_O(motors), .MAIN_FUNCTION_O(fn), .RUN_LAUNCH_O(run_p),
    .HALT_ALL_O(halt_p), .HOLD_TASKS_O(hold_p), .RESUME_TASKS_O(res_p),
    .FAULT_CLEAR_O(fclr_p), .GENERAL_OUT_CLEAR_O(goclr_p), .PARAM_INIT_O(pinit_p),
    .MOTOR_ON_O(mon_p), .MOTOR_OFF_O(moff_p), .PARK_MOVE_O(park_p), .LOW_POWER_O(lp_o)
  );

  remote_panel_model remote_panel_model_i (
    .clk_i(clk), .rst_n_i(rst_n), .go_i(go), .cmd_i(cmd), .sel_i(sel), .gin_o(gin),
    .mon_o(mon), .moff_o(moff), .park_o(park), .lowpwr_o(lowpwr), .busy_o(busy)
  );

  assign pulses = {lp_o, park_p, moff_p, mon_p, pinit_p, goclr_p, fclr_p, res_p,
                   hold_p, halt_p, run_p};

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_chk

  // one command through the panel, every action pulse gathered
  task automatic cmd_check(input logic [3:0] c, input logic [10:0] e);
    int k = 0;
    while (busy && k < 100) begin
      @(posedge clk);
      k++;
    end
    if (busy) begin
      n_errors++;
      wrap_up();
    end
    @(posedge clk);
    cmd <= c;
    go  <= 1'b1;
    @(posedge clk);
    go     <= 1'b0;
    seen   = '0;
    n_halt = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      seen |= pulses;
      if (halt_p === 1'b1) n_halt++;
    end
    chk(32'(seen), 32'(e));
  endtask : cmd_check

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    {rst_n, wr, rd, go, err_ev, estop, crit, warn} = 8'h00;
    ctx   = 6'h30;
    cmd   = 4'h0;
    sel   = 3'h0;
    addr  = '0;
    wdata = '0;
    n_errors        = 0;
    samples_checked = 0;
    rows = '{'{6'h30, 4'd0, 11'h001}, '{6'h28, 4'd0, 11'h000},
             '{6'h32, 4'd0, 11'h000}, '{6'h10, 4'd0, 11'h000},
             '{6'h30, 4'd1, 11'h002}, '{6'h28, 4'd2, 11'h004},
             '{6'h30, 4'd2, 11'h000}, '{6'h2c, 4'd3, 11'h008},
             '{6'h28, 4'd3, 11'h000}, '{6'h30, 4'd4, 11'h070},
             '{6'h28, 4'd4, 11'h000}, '{6'h30, 4'd5, 11'h0c0},
             '{6'h32, 4'd5, 11'h000}, '{6'h30, 4'd6, 11'h100},
             '{6'h28, 4'd6, 11'h000}, '{6'h31, 4'd7, 11'h200},
             '{6'h30, 4'd7, 11'h000}};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(32'({pulses, gout, remote, fn}), 32'h10);
    rd_chk(REG_CTRL, 32'h0);
    wr_reg(REG_CTRL, 32'h1);
    rd_chk(REG_CTRL, 32'h1);
    rd_chk(4'hc, 32'h0);
    rd_chk(REG_STATUS, 32'h101);
    chk(32'(remote), 32'h1);
    $display("test registers done");
    for (int i = 0; i < 17; i++) begin
      @(posedge clk);
      ctx <= rows[i].ctx;
      repeat (3) @(posedge clk);
      cmd_check(rows[i].cmd, rows[i].exp);
    end
    $display("test table done");
    @(posedge clk);
    ctx    <= 6'h30;
    err_ev <= 1'b1;
    @(posedge clk);
    err_ev <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(gout[GOUT_ERROR]), 32'h1);
    cmd_check(4'd0, 11'h000);
    cmd_check(4'd4, 11'h070);
    cmd_check(4'd0, 11'h001);
    $display("test error done");
    @(posedge clk);
    ctx   <= 6'h3f;
    estop <= 1'b1;
    crit  <= 1'b1;
    warn  <= 1'b1;
    @(posedge clk);
    estop <= 1'b0;
    rd_chk(REG_STATUS, 32'h3f4);
    chk(32'(motors), 32'h1);
    @(posedge clk);
    ctx  <= 6'h30;
    crit <= 1'b0;
    warn <= 1'b0;
    cmd_check(4'd4, 11'h070);
    chk(32'(gout), 32'h01);
    $display("test status done");
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      sel <= 3'(s);
      cmd_check(4'd0, 11'h001);
      chk(32'(fn), 32'(s));
    end
    rd_chk(REG_LAST, 32'h0007_0001);
    $display("test select done");
    wr_reg(REG_CTRL, 32'h0);
    cmd_check(4'd8, 11'h402);
    chk(32'(n_halt), 32'h2);
    cmd_check(4'd0, 11'h000);
    $display("test low power done");
    wrap_up();
  end
endmodule : tb
